// ### hw/asc_defs.svh
/*
 * timing counts, status values, warning and error codes for one axis.
 * assumes a 25 MHz clock; included by bare name.
 */
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define ASC_CLK_NS 40
`define ASC_CLK_HZ 33'h0_017D_7840
// speed-change calculation time, in ns
`define ASC_CALC_NS 100000
`define ASC_CALC_CYC ((`ASC_CALC_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_RAMP_STEP 32'h0000_0064
`define ASC_DEC_SHIFT 6
`define ASC_TIME_MAX 16'h7FFF

// ----------------------------------------
// operation status values
// ----------------------------------------
`define ASC_STS_STANDBY 16'h0000
`define ASC_STS_JOG 16'h0001
`define ASC_STS_ORIGIN 16'h0002
`define ASC_STS_POS 16'h0003
`define ASC_STS_SPD 16'h0004
`define ASC_STS_SPDPOS 16'h0005
`define ASC_STS_ERROR 16'hFFFF

// ----------------------------------------
// warning and error codes
// ----------------------------------------
`define ASC_W_RANGE 16'h03FC
`define ASC_W_NOCHG 16'h03FE
`define ASC_E_STROKE_P 16'h044F
`define ASC_E_STROKE_N 16'h0450
`define ASC_E_ACCT 16'h05DE
`define ASC_E_STOPT 16'h05DF
`define ASC_NONE 16'h0000

`endif

// ### hw/asc_pkg.sv
/*
 * types shared by the axis logic and its surroundings.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package asc_pkg;

   typedef logic signed [31:0] asc_pos_t;
   typedef logic [31:0] asc_spd_t;
   typedef logic [15:0] asc_time_t;

   typedef enum logic [3:0] {
      CTL_MACH_ORG, CTL_FAST_ORG, CTL_FAST_STBY, CTL_POS, CTL_SPD,
      CTL_SPD_POS, CTL_CUR_CHG, CTL_JOG, CTL_POS_RESTORE
   } asc_ctl_e;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL} asc_st_e;

   typedef struct packed {
      asc_ctl_e ctl;
      logic incr;
      logic fwd;
      asc_pos_t addr;
      asc_spd_t spd;
   } asc_start_s;

   typedef struct packed {
      asc_spd_t spd;
      asc_time_t acc_t;
      asc_time_t stop_t;
   } asc_spc_s;

   typedef struct packed {
      asc_pos_t lim_hi;
      asc_pos_t lim_lo;
      asc_spd_t spd_lim;
      asc_spd_t bias;
      asc_pos_t origin_address;
      asc_pos_t stby_addr;
      asc_time_t jog_dec_t;
      asc_time_t stop_t;
   } asc_cfg_s;

endpackage

// ### hw/asc_axis.sv
/*
 * one pulse-train positioning axis: start checks against the software
 * stroke limits, on-the-fly speed and target changes, pulse output.
 * assumes all inputs synchronous to clk and a drive taking pulse/dir.
 */
`timescale 1ns/100ps
`include "asc_defs.svh"

// What this block does
// [RULE1] new speed above limit runs at limit, warns
// [RULE2] new speed below bias runs at bias, warns
// [RULE3] refuse speed change while calculation runs
// [RULE4] new speed applies only at pulse completion
// [RULE5] target reached during calculation: keep speed, warn
// [RULE6] target change with speed change cancels it, warns
// [RULE7] target change while accelerating holds current speed
// [RULE8] positioning may end above bias speed
// [RULE9] zero speed with zero bias stops, stays busy
// [RULE10] zero speed with nonzero bias warns, runs bias
// [RULE11] time error at speed zero stops, status error
// [RULE12] time error at change start sets status error
// [RULE13] after time error keep previous stop time
// [RULE14] jog time error uses previous jog stop time
// [RULE15] change stop time refers to new speed
// [RULE16] stroke limits checked at start and run
// [RULE17] no start check for some controls
// [RULE18] fast return to origin: check feed, address
// [RULE19] fast return to standby: check feed, address
// [RULE20] position control: check feed and target
// [RULE21] out-of-range current value change refused
// [RULE22] jog from outside: only inward start allowed
// [RULE23] switch already on starts in position phase
module asc_axis (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // operation start
   input wire logic start,
   input wire asc_pkg::asc_start_s start_req,
   input wire logic ext_switch,
   // on-the-fly changes
   input wire logic speed_change_command,
   input wire asc_pkg::asc_spc_s spc_req,
   input wire logic target_position_change_command,
   input wire asc_pkg::asc_pos_t new_target,
   // settings and error clear
   input wire asc_pkg::asc_cfg_s cfg,
   input wire logic err_reset,
   // drive side
   output logic pulse_out,
   output logic dir_out,
   // status
   output logic axis_busy_flag,
   output logic [15:0] axis_operation_status,
   output logic [15:0] current_feed_value_low,
   output logic [15:0] current_feed_value_high,
   output logic [15:0] warn_code,
   output logic [15:0] err_code,
   output asc_pkg::asc_spd_t cur_speed,
   output asc_pkg::asc_time_t act_stop_time,
   output asc_pkg::asc_spd_t stop_ref_speed
);

   localparam logic [11:0] CALC_CYC = 12'(`ASC_CALC_CYC);

   // ----------------------------------------
   // state
   // ----------------------------------------
   asc_pkg::asc_st_e st_q, st_d;
   asc_pkg::asc_ctl_e ctl_q;
   asc_pkg::asc_pos_t feed_q, tgt_q;
   asc_pkg::asc_spd_t cur_q, tgt_spd_q, acc_q, pend_spd_q, ref_q;
   asc_pkg::asc_time_t stop_q, pend_stop_q;
   logic [11:0] calc_q;
   logic pos_ph_q, fwd_q, last_ok_q, busy_q, pulse_q, sw_q;
   logic [15:0] sts_q, warn_q, err_q;

   function automatic logic in_rng(input asc_pkg::asc_pos_t a,
                                   input asc_pkg::asc_cfg_s c);
      in_rng = (a >= c.lim_lo) && (a <= c.lim_hi);
   endfunction

   // ----------------------------------------
   // pulse generation
   // ----------------------------------------
   wire moving = st_q != asc_pkg::ST_IDLE;
   wire run = st_q == asc_pkg::ST_RUN;
   wire [32:0] acc_sum = {1'b0, acc_q} + {1'b0, cur_q};
   wire pulse_evt = moving && (acc_sum >= `ASC_CLK_HZ);
   // speed may only move on a pulse edge, or while the speed stands at zero
   wire bound = pulse_evt || (cur_q == '0); // [RULE4]
   wire asc_pkg::asc_pos_t step_pos = fwd_q ? feed_q + 1 : feed_q - 1;
   wire chk_run = pos_ph_q || (ctl_q == asc_pkg::CTL_JOG);
   wire run_out = pulse_evt && chk_run &&
      (fwd_q ? step_pos > cfg.lim_hi : step_pos < cfg.lim_lo); // [RULE16]
   wire at_tgt = moving && pos_ph_q && (feed_q == tgt_q);
   wire asc_pkg::asc_pos_t rem = fwd_q ? tgt_q - feed_q : feed_q - tgt_q;
   wire near = pos_ph_q && ($unsigned(rem) <= (cur_q >> `ASC_DEC_SHIFT));

   // ----------------------------------------
   // start decode and stroke check
   // ----------------------------------------
   wire asc_pkg::asc_ctl_e sctl = start_req.ctl;
   wire start_go = start && !busy_q;
   wire asc_pkg::asc_pos_t st_tgt =
      (sctl == asc_pkg::CTL_FAST_ORG || sctl == asc_pkg::CTL_MACH_ORG)
         ? cfg.origin_address :
      (sctl == asc_pkg::CTL_FAST_STBY) ? cfg.stby_addr :
      (start_req.incr && sctl != asc_pkg::CTL_CUR_CHG)
         ? feed_q + start_req.addr : start_req.addr;
   wire st_pos = sctl == asc_pkg::CTL_MACH_ORG ||
      sctl == asc_pkg::CTL_FAST_ORG || sctl == asc_pkg::CTL_FAST_STBY ||
      sctl == asc_pkg::CTL_POS || sctl == asc_pkg::CTL_POS_RESTORE ||
      (sctl == asc_pkg::CTL_SPD_POS && ext_switch); // [RULE23]
   // machine return, speed, speed phase and restoration skip this
   wire st_chk = sctl == asc_pkg::CTL_FAST_ORG || // [RULE17] [RULE18]
      sctl == asc_pkg::CTL_FAST_STBY || sctl == asc_pkg::CTL_POS || // [RULE19]
      (sctl == asc_pkg::CTL_SPD_POS && ext_switch); // [RULE20]
   wire bad_ft = st_chk &&
      (!in_rng(feed_q, cfg) || !in_rng(st_tgt, cfg)); // [RULE20]
   wire bad_cv = sctl == asc_pkg::CTL_CUR_CHG && !in_rng(st_tgt, cfg); // [RULE21]
   wire bad_jog = sctl == asc_pkg::CTL_JOG &&
      (start_req.fwd ? feed_q > cfg.lim_hi
                     : feed_q < cfg.lim_lo); // [RULE22]
   wire st_bad = start_go && (bad_ft || bad_cv || bad_jog);
   wire st_plus = (sctl == asc_pkg::CTL_JOG) ? start_req.fwd
      : (feed_q > cfg.lim_hi || st_tgt > cfg.lim_hi);
   wire st_runs = start_go && !st_bad && sctl != asc_pkg::CTL_CUR_CHG;
   wire cv_go = start_go && !st_bad && sctl == asc_pkg::CTL_CUR_CHG;
   wire st_fwd = st_pos ? st_tgt > feed_q : start_req.fwd;

   // switching from speed phase to position phase mid-run
   wire sw_rise = run && ctl_q == asc_pkg::CTL_SPD_POS && !pos_ph_q &&
      ext_switch && !sw_q;
   wire asc_pkg::asc_pos_t sw_tgt = feed_q + tgt_q;
   wire sw_bad = sw_rise &&
      (!in_rng(feed_q, cfg) || !in_rng(sw_tgt, cfg)); // [RULE16]

   // ----------------------------------------
   // speed change and target change decode
   // ----------------------------------------
   wire acc_ok = spc_req.acc_t != '0 && spc_req.acc_t <= `ASC_TIME_MAX;
   wire stp_ok = spc_req.stop_t != '0 && spc_req.stop_t <= `ASC_TIME_MAX;
   wire spc_go = speed_change_command && run && calc_q == '0; // [RULE3]
   wire spc_cancel = spc_go && target_position_change_command; // [RULE6]
   wire spc_terr = spc_go && !spc_cancel && !(acc_ok && stp_ok); // [RULE12]
   wire spc_acc = spc_go && !spc_cancel && acc_ok && stp_ok;
   wire spd_hi = spc_req.spd > cfg.spd_lim;
   wire spd_lo = spc_req.spd < cfg.bias;
   // zero with zero bias is in range and simply stops the axis
   wire asc_pkg::asc_spd_t spd_cl = spd_hi ? cfg.spd_lim : // [RULE1]
      spd_lo ? cfg.bias : spc_req.spd; // [RULE2] [RULE9] [RULE10]
   wire calc_abort = calc_q != '0 && at_tgt; // [RULE5]
   wire calc_done = calc_q == 12'h001 && !at_tgt;
   wire terr_stop = spc_terr && cur_q == '0; // [RULE11]
   // position keeps going to its end; others decelerate now
   wire terr_dec = spc_terr && !pos_ph_q && cur_q != '0; // [RULE13]
   wire tpc_go = target_position_change_command && run && pos_ph_q;
   wire accel = cur_q < tgt_spd_q;
   wire asc_pkg::asc_spd_t st_spd = start_req.spd > cfg.spd_lim
      ? cfg.spd_lim : start_req.spd;

   // ----------------------------------------
   // ramp toward the effective target speed
   // ----------------------------------------
   // positioning ends at the target even if still above bias
   wire asc_pkg::asc_spd_t eff = (st_q == asc_pkg::ST_DECEL) ? '0 :
      near ? cfg.bias : tgt_spd_q; // [RULE8]
   wire asc_pkg::asc_spd_t up = (eff - cur_q > `ASC_RAMP_STEP)
      ? cur_q + `ASC_RAMP_STEP : eff;
   wire asc_pkg::asc_spd_t dn = (cur_q - eff > `ASC_RAMP_STEP)
      ? cur_q - `ASC_RAMP_STEP : eff;
   wire asc_pkg::asc_spd_t ramp = (cur_q < eff) ? up : dn;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         asc_pkg::ST_IDLE: begin
            if (st_runs)
               st_d = asc_pkg::ST_RUN;
         end
         asc_pkg::ST_RUN: begin
            if (at_tgt || run_out || terr_stop)
               st_d = asc_pkg::ST_IDLE;
            else if (terr_dec || sw_bad)
               st_d = asc_pkg::ST_DECEL;
         end
         asc_pkg::ST_DECEL: begin
            if (at_tgt || run_out || (cur_q == '0))
               st_d = asc_pkg::ST_IDLE;
         end
         default: st_d = asc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= asc_pkg::ST_IDLE;
         busy_q <= 1'b0;
         sw_q <= 1'b0;
      end else begin
         st_q <= st_d;
         // in ST_RUN zero speed alone never ends a run, so busy stays set
         busy_q <= st_d != asc_pkg::ST_IDLE; // [RULE9]
         sw_q <= ext_switch;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl_q <= asc_pkg::CTL_MACH_ORG;
         pos_ph_q <= 1'b0;
         fwd_q <= 1'b1;
         tgt_q <= '0;
      end else if (st_runs) begin
         ctl_q <= sctl;
         pos_ph_q <= st_pos;
         fwd_q <= st_fwd;
         tgt_q <= (sctl == asc_pkg::CTL_SPD_POS && !ext_switch)
            ? start_req.addr : st_tgt;
      end else if (sw_rise) begin
         pos_ph_q <= 1'b1;
         tgt_q <= sw_tgt;
         fwd_q <= sw_tgt > feed_q;
      end else if (tpc_go) begin
         tgt_q <= new_target;
         fwd_q <= new_target > feed_q;
      end
   end

   // ----------------------------------------
   // feed value and pulses
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         feed_q <= '0;
         acc_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= pulse_evt && !run_out;
         if (!moving)
            acc_q <= '0;
         else if (pulse_evt)
            acc_q <= 32'(acc_sum - `ASC_CLK_HZ);
         else
            acc_q <= acc_sum[31:0];
         if (cv_go)
            feed_q <= st_tgt; // [RULE21]
         else if (pulse_evt && !run_out)
            feed_q <= step_pos;
      end
   end

   // ----------------------------------------
   // speed, stop time and calculation window
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur_q <= '0;
         tgt_spd_q <= '0;
      end else if (st_runs) begin
         cur_q <= cfg.bias;
         tgt_spd_q <= (st_spd < cfg.bias) ? cfg.bias : st_spd;
      end else if (st_d == asc_pkg::ST_IDLE) begin
         cur_q <= '0;
      end else begin
         if (bound)
            cur_q <= ramp; // [RULE4]
         if (tpc_go && accel)
            tgt_spd_q <= cur_q; // [RULE7]
         else if (calc_done)
            tgt_spd_q <= pend_spd_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         calc_q <= '0;
         pend_spd_q <= '0;
         pend_stop_q <= '0;
      end else if (spc_acc) begin
         calc_q <= CALC_CYC; // [RULE3]
         pend_spd_q <= spd_cl;
         pend_stop_q <= spc_req.stop_t;
      end else if (calc_abort || !moving) begin
         calc_q <= '0; // [RULE5]
      end else if (calc_q != '0) begin
         calc_q <= calc_q - 12'h001;
      end
   end

   // a failed change leaves the stop time untouched, so the one in
   // force (jog or start stop time, or last good change) stays on act_stop_time
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stop_q <= '0;
         ref_q <= '0;
         last_ok_q <= 1'b0;
      end else if (st_runs) begin
         stop_q <= (sctl == asc_pkg::CTL_JOG) ? cfg.jog_dec_t : cfg.stop_t;
         ref_q <= (st_spd < cfg.bias) ? cfg.bias : st_spd;
         last_ok_q <= 1'b0;
      end else if (calc_done) begin
         stop_q <= pend_stop_q; // [RULE13] [RULE14]
         ref_q <= pend_spd_q; // [RULE15]
         last_ok_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // status, warnings and errors
   // ----------------------------------------
   wire err_evt = st_bad || run_out || sw_bad || spc_terr;
   wire warn_rng = spc_acc && (spd_hi || spd_lo); // [RULE1] [RULE2] [RULE10]
   wire warn_nochg = spc_cancel || calc_abort; // [RULE5] [RULE6]
   wire asc_pkg::asc_ctl_e rctl = st_runs ? sctl : ctl_q;
   wire [15:0] run_sts =
      (rctl == asc_pkg::CTL_JOG) ? `ASC_STS_JOG :
      (rctl == asc_pkg::CTL_SPD) ? `ASC_STS_SPD :
      (rctl == asc_pkg::CTL_SPD_POS) ? `ASC_STS_SPDPOS :
      (rctl == asc_pkg::CTL_POS) ? `ASC_STS_POS : `ASC_STS_ORIGIN;
   wire [15:0] err_val =
      spc_terr ? (acc_ok ? `ASC_E_STOPT : `ASC_E_ACCT) :
      st_bad ? (st_plus ? `ASC_E_STROKE_P : `ASC_E_STROKE_N) :
      (fwd_q ? `ASC_E_STROKE_P : `ASC_E_STROKE_N);
   wire run_end = moving && st_d == asc_pkg::ST_IDLE;

   // an event in the clearing cycle wins over the clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sts_q <= `ASC_STS_STANDBY;
         warn_q <= `ASC_NONE;
         err_q <= `ASC_NONE;
      end else begin
         if (err_evt)
            sts_q <= `ASC_STS_ERROR; // [RULE11] [RULE12]
         else if (st_runs)
            sts_q <= run_sts;
         else if (run_end && sts_q != `ASC_STS_ERROR)
            sts_q <= `ASC_STS_STANDBY;
         else if (err_reset && !busy_q)
            sts_q <= `ASC_STS_STANDBY;
         if (err_evt)
            err_q <= err_val;
         else if (err_reset)
            err_q <= `ASC_NONE;
         if (warn_nochg)
            warn_q <= `ASC_W_NOCHG;
         else if (warn_rng)
            warn_q <= `ASC_W_RANGE;
         else if (err_reset)
            warn_q <= `ASC_NONE;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign pulse_out = pulse_q;
   assign dir_out = fwd_q;
   assign axis_busy_flag = busy_q;
   assign axis_operation_status = sts_q;
   assign current_feed_value_low = feed_q[15:0];
   assign current_feed_value_high = feed_q[31:16];
   assign warn_code = warn_q;
   assign err_code = err_q;
   assign cur_speed = cur_q;
   assign act_stop_time = stop_q;
   assign stop_ref_speed = ref_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_clamp_high: assert property ( // [RULE1]
      spc_acc && spd_hi && !spc_req.spd[31] |=> pend_spd_q == cfg.spd_lim
      && warn_q == `ASC_W_RANGE)
      else $error("speed above limit not clamped");
   a_clamp_low: assert property ( // [RULE2]
      spc_acc && spd_lo && !warn_nochg |=> pend_spd_q == $past(cfg.bias)
      && warn_q == `ASC_W_RANGE)
      else $error("speed below bias not raised");
   a_calc_refuse: assert property ( // [RULE3]
      calc_q > 12'h001 && !calc_abort && moving |=>
      calc_q == $past(calc_q) - 12'h001)
      else $error("speed change taken during calculation");
   a_pulse_bound: assert property ( // [RULE4]
      $changed(cur_q) && $past(moving) && st_q != asc_pkg::ST_IDLE &&
      !$past(st_runs) |-> $past(bound))
      else $error("speed changed mid pulse");
   a_both_cancel: assert property ( // [RULE6]
      spc_cancel |=> warn_q == `ASC_W_NOCHG && calc_q == '0)
      else $error("simultaneous change not cancelled");
   a_time_error: assert property ( // [RULE12]
      spc_terr |=> sts_q == `ASC_STS_ERROR ##1 sts_q == `ASC_STS_ERROR)
      else $error("time error not shown in status");
   a_zero_busy: assert property ( // [RULE9]
      run && cur_q == '0 && !at_tgt && !spc_terr && !run_out |=> busy_q)
      else $error("busy dropped at zero speed");
   a_stroke_start: assert property ( // [RULE20]
      st_bad |=> !busy_q && (err_q == `ASC_E_STROKE_P ||
      err_q == `ASC_E_STROKE_N))
      else $error("out-of-stroke start not refused");
   a_curval_keep: assert property ( // [RULE21]
      start_go && bad_cv |=> feed_q == $past(feed_q))
      else $error("current value changed out of range");
   a_stop_keep: assert property ( // [RULE13]
      spc_terr |=> stop_q == $past(stop_q))
      else $error("stop time altered by failed change");

   c_spc_done: cover property (calc_done);
   c_tgt_abort: cover property (calc_abort);
   c_jog_inward: cover property (st_runs && sctl == asc_pkg::CTL_JOG &&
      !in_rng(feed_q, cfg));
   c_switch_pos: cover property (sw_rise);

endmodule

// ### bench/asc_drive_model.sv
/*
 * pulse-train drive model: counts steps by direction into a position.
 * assumes registered one-cycle pulses from the axis on the same clock.
 */
`timescale 1ns/100ps
module asc_drive_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pulse train from the axis
   input wire logic pulse_in,
   input wire logic dir_in,
   // accumulated position
   output asc_pkg::asc_pos_t pos_q
);
   // a real drive has no idea of the feed value, so only steps count here
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pos_q <= 32'h0000_0000;
      end else if (pulse_in) begin
         pos_q <= dir_in ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
      end
   end
endmodule

// ### bench/asc_tb_top.sv
/*
 * self-checking bench for one axis: stroke checks at start, a move,
 * speed changes and a jog start from outside the limits.
 * assumes the axis and drive model compiled before it.
 */
`timescale 1ns/100ps
`include "asc_defs.svh"
module axis_speed_change_and_stroke_limit_tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk, rst_n, start, ext_switch, err_reset, pulse_out, dir_out, busy;
   logic speed_change_command, target_position_change_command;
   asc_pkg::asc_start_s start_req;
   asc_pkg::asc_spc_s spc_req;
   asc_pkg::asc_pos_t new_target, model_pos;
   asc_pkg::asc_cfg_s cfg;
   logic [15:0] status, feed_lo, feed_hi, warn_code, err_code;
   asc_pkg::asc_spd_t cur_speed, stop_ref_speed;
   asc_pkg::asc_time_t act_stop_time;
   logic [31:0] feed;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   assign feed = {feed_hi, feed_lo};

   asc_axis i_dut (.clk(clk), .rst_n(rst_n), .start(start),
      .start_req(start_req), .ext_switch(ext_switch),
      .speed_change_command(speed_change_command), .spc_req(spc_req),
      .target_position_change_command(target_position_change_command),
      .new_target(new_target), .cfg(cfg), .err_reset(err_reset),
      .pulse_out(pulse_out), .dir_out(dir_out), .axis_busy_flag(busy),
      .axis_operation_status(status), .current_feed_value_low(feed_lo),
      .current_feed_value_high(feed_hi), .warn_code(warn_code),
      .err_code(err_code), .cur_speed(cur_speed),
      .act_stop_time(act_stop_time), .stop_ref_speed(stop_ref_speed));
   asc_drive_model i_drive (.clk(clk), .rst_n(rst_n), .pulse_in(pulse_out),
      .dir_in(dir_out), .pos_q(model_pos));

   // ----------------------------------------
   // clock, timeout, helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // the run needs about 6000 cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         summarize();
      end
   end
   task summarize;
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_tests++;
      if (seen !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task go(input asc_pkg::asc_ctl_e c, input logic f, input logic [31:0] a);
      start_req = '{ctl: c, incr: 1'b0, fwd: f, addr: a,
         spd: 32'h000F_4240};
      start = 1'b1;
      tick(1);
      start = 1'b0;
      tick(2);
   endtask
   task spc(input logic [31:0] s, input logic [15:0] a, input logic tp);
      spc_req = '{spd: s, acc_t: a, stop_t: 16'h0064};
      new_target = 32'h0000_0258;
      speed_change_command = 1'b1;
      target_position_change_command = tp;
      tick(1);
      speed_change_command = 1'b0;
      target_position_change_command = 1'b0;
      tick(2);
   endtask
   task clr;
      err_reset = 1'b1;
      tick(2);
      err_reset = 1'b0;
      tick(1);
   endtask
   task rst;
      rst_n = 1'b0;
      tick(16);
      rst_n = 1'b1;
      tick(1);
   endtask
   task stroke(input asc_pkg::asc_ctl_e c, input logic [31:0] a,
               input logic [15:0] e);
      go(c, 1'b1, a);
      chk("err_code", err_code, e);
      chk("busy", busy, 1'b0);
      chk("status", status, `ASC_STS_ERROR);
      chk("feed", feed, 32'h0000_0000);
      clr();
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      {start, ext_switch, err_reset} = 3'b000;
      {speed_change_command, target_position_change_command} = 2'b00;
      start_req = '0;
      spc_req = '0;
      new_target = '0;
      cfg = '{lim_hi: 32'h0000_03E8, lim_lo: 32'hFFFF_FC18,
         spd_lim: 32'h001E_8480, bias: 32'h0007_A120,
         origin_address: 32'h0000_0000, stby_addr: 32'h0000_07D0,
         jog_dec_t: 16'h0064, stop_t: 16'h0064};
      rst();
      chk("busy", busy, 1'b0);
      chk("dir_out", dir_out, 1'b1);
      chk("status", status, `ASC_STS_STANDBY);
      chk("cur_speed", cur_speed, 32'h0000_0000);
      $display("test reset done");
      stroke(asc_pkg::CTL_CUR_CHG, 32'h0000_03E9, `ASC_E_STROKE_P);
      stroke(asc_pkg::CTL_POS, 32'h0000_07D0, `ASC_E_STROKE_P);
      stroke(asc_pkg::CTL_POS, 32'hFFFF_F830, `ASC_E_STROKE_N);
      stroke(asc_pkg::CTL_FAST_STBY, 32'h0, `ASC_E_STROKE_P);
      $display("test start stroke checks done");
      go(asc_pkg::CTL_POS, 1'b1, 32'h0000_000A);
      chk("busy", busy, 1'b1);
      chk("status", status, `ASC_STS_POS);
      for (int i = 0; i < 5000 && busy !== 1'b0; i++) tick(1);
      chk("feed", feed, 32'h0000_000A);
      chk("drive pos", model_pos, 32'h0000_000A);
      $display("test position move done");
      go(asc_pkg::CTL_SPD, 1'b1, 32'h0);
      chk("busy", busy, 1'b1);
      // no pulse is due yet, so the speed still stands at bias
      chk("cur_speed", cur_speed, cfg.bias);
      spc(32'h002D_C6C0, 16'h0064, 1'b0);
      chk("warn_code", warn_code, `ASC_W_RANGE);
      tick(5);
      // lands inside the calculation window of the first change
      spc(32'h0016_E360, 16'h0064, 1'b0);
      tick(2600);
      chk("stop_ref_speed", stop_ref_speed, cfg.spd_lim);
      chk("act_stop_time", act_stop_time, 16'h0064);
      spc(32'h0000_0064, 16'h0064, 1'b0);
      tick(2600);
      chk("stop_ref_speed", stop_ref_speed, cfg.bias);
      spc(32'h000F_4240, 16'h0000, 1'b0);
      chk("err_code", err_code, `ASC_E_ACCT);
      chk("status", status, `ASC_STS_ERROR);
      rst();
      $display("test speed change done");
      go(asc_pkg::CTL_POS, 1'b1, 32'h0000_01F4);
      spc(32'h000F_4240, 16'h0064, 1'b1);
      chk("warn_code", warn_code, `ASC_W_NOCHG);
      rst();
      $display("test simultaneous change done");
      cfg.lim_lo = 32'h0000_0064;
      go(asc_pkg::CTL_JOG, 1'b0, 32'h0);
      chk("err_code", err_code, `ASC_E_STROKE_N);
      chk("busy", busy, 1'b0);
      clr();
      go(asc_pkg::CTL_JOG, 1'b1, 32'h0);
      chk("busy", busy, 1'b1);
      chk("err_code", err_code, `ASC_NONE);
      $display("test jog from outside done");
      summarize();
   end
endmodule
